// ### design/s3pm_pkg.sv
// Package for the serial-three pin function select block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and eight pads.
package s3pm_pkg;
   // Byte offsets of the bus-visible registers
   localparam logic [3:0] S3PM_OFS_CTRL = 4'h0; // Bit 0 holds configuration state
   localparam logic [3:0] S3PM_OFS_INDEX = 4'h4; // Configuration index register
   localparam logic [3:0] S3PM_OFS_DATA = 4'h8; // Window onto the indexed register
   localparam logic [3:0] S3PM_OFS_STATUS = 4'hc; // Read-only view of both mux registers

   // Index values that open the two mux registers
   localparam logic [7:0] S3PM_IDX_MUX_LOW = 8'h48;
   localparam logic [7:0] S3PM_IDX_MUX_HIGH = 8'h49;

   // Reset values
   localparam logic [7:0] S3PM_MUX_RESET = 8'h00;
   localparam logic [7:0] S3PM_INDEX_RESET = 8'h00;
   localparam logic [31:0] S3PM_RDATA_RESET = 32'h0000_0000;

   // Field layout: four 2-bit selectors per register
   localparam int S3PM_FIELD_W = 2;
   localparam int S3PM_PINS = 8;
   localparam int S3PM_CFG_BIT = 0;

   // Field codes
   localparam logic [1:0] S3PM_FN_GPIO = 2'h0;
   localparam logic [1:0] S3PM_FN_ALT = 2'h1;

   // Pads whose serial function is an output (transmit, request to send, terminal ready)
   localparam logic [7:0] S3PM_ALT_OUT_MASK = 8'ha8;
   // Level seen by the serial port on an unrouted input: idle mark / inactive
   localparam logic S3PM_ALT_IDLE = 1'b1;

   // Bus handshake states, Gray along idle -> answer
   typedef enum logic [1:0] {
      S3PM_FSM_IDLE = 2'h0,
      S3PM_FSM_ACK = 2'h1
   } s3pm_fsm_t;

   // Whole state of the top module
   typedef struct packed {
      s3pm_fsm_t fsm;
      logic cfg;
      logic [7:0] index;
      logic [31:0] rdata;
   } s3pm_state_t;

   // Whole state of one mux register
   typedef struct packed {
      logic [7:0] value;
   } s3pm_mux_state_t;

   // Drive of one pad
   typedef struct packed {
      logic out;
      logic oe;
   } s3pm_pad_drive_t;
endpackage

// ### design/s3pm_mux_reg.sv
// One 8-bit pin mux register holding four 2-bit function selectors.
// Assumes the caller qualifies wr_en with configuration state and index.
module s3pm_mux_reg
   import s3pm_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);
   s3pm_mux_state_t st_q; // Registered state
   s3pm_mux_state_t st_d; // Next state

   // Next value: every bit is plain read/write storage
   always_comb begin
      st_d = st_q;
      if (wr_en) begin
         st_d.value = wr_data;
      end
   end

   // Standby power-on reset puts every pad back to GPIO
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_q.value <= S3PM_MUX_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign value = st_q.value;
endmodule // s3pm_mux_reg

// ### design/s3pm_pin_cell.sv
// Routing of one pad between the GPIO block and one serial-three signal.
// Assumes pad direction comes from the GPIO direction setting.
module s3pm_pin_cell
   import s3pm_pkg::*;
#(
   parameter bit ALT_IS_OUTPUT = 1'b0
)
(
   input wire logic [1:0] sel,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   input wire logic pad_in,
   input wire logic alt_out,
   output s3pm_pad_drive_t pad,
   output logic gpio_in,
   output logic alt_in
);
   logic alt_sel; // Serial function chosen; reserved codes fall back to GPIO

   assign alt_sel = (sel == S3PM_FN_ALT);

   // Direction is left to the GPIO direction bit, which software sets to suit
   assign pad.oe = gpio_oe;
   assign pad.out = (ALT_IS_OUTPUT && alt_sel) ? alt_out : gpio_out;
   // The GPIO input still sees the pad, so GPIO events keep working
   assign gpio_in = pad_in;
   // An unrouted serial input sees its idle level, never a floating pad
   assign alt_in = alt_sel ? pad_in : S3PM_ALT_IDLE;
endmodule // s3pm_pin_cell

// ### design/s3pm_top.sv
// Serial-three pin function select: Avalon-MM slave, index/data access, pad routing.
// Assumes a single 200 MHz clock and resetn as the standby power-on reset.
//
// The Avalon-MM slave port is this design's own decision.
module s3pm_top
   import s3pm_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // GPIO block side, bit 0 is gpio_pin_30 up to bit 7 gpio_pin_37
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe,
   output logic [7:0] gpio_in,
   // Pads, same bit order
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   // Serial port three side
   output logic port3_ring_indicator_n,
   output logic port3_carrier_detect_n,
   output logic port3_receive_data,
   input wire logic port3_transmit_data,
   output logic port3_data_set_ready_n,
   input wire logic port3_request_to_send_n,
   output logic port3_clear_to_send_n,
   input wire logic port3_terminal_ready_n
);
   s3pm_state_t st_q; // Registered state
   s3pm_state_t st_d; // Next state
   logic req; // A bus request is present
   logic accept; // Request completes at this edge
   logic wr_low; // Write strobe into the low mux register
   logic wr_high; // Write strobe into the high mux register
   logic [7:0] mux_low; // Selectors for pins 30-33
   logic [7:0] mux_high; // Selectors for pins 34-37
   logic [15:0] sel_all; // Both registers side by side
   logic [7:0] alt_out; // Serial outputs lined up by pad
   logic [7:0] alt_in; // Serial inputs lined up by pad
   logic [7:0] data_view; // Value behind the data window
   logic [31:0] rd_value; // Read value prepared for the answer
   logic lane0; // Low byte lane written
   s3pm_pad_drive_t pad_drv [S3PM_PINS]; // Per-pad drive

   assign req = read | write;
   // One wait cycle per access keeps the read path registered
   assign waitrequest = req && (st_q.fsm != S3PM_FSM_ACK);
   assign accept = req && (st_q.fsm == S3PM_FSM_ACK);
   assign lane0 = byteenable[0];

   // Data window decode: only in configuration state and with a matching index
   assign wr_low = accept && write && lane0 && (address == S3PM_OFS_DATA) && st_q.cfg
                   && (st_q.index == S3PM_IDX_MUX_LOW);
   assign wr_high = accept && write && lane0 && (address == S3PM_OFS_DATA) && st_q.cfg
                    && (st_q.index == S3PM_IDX_MUX_HIGH);

   // Value seen through the data window
   always_comb begin
      data_view = 8'h00;
      if (st_q.cfg) begin
         case (st_q.index)
            S3PM_IDX_MUX_LOW: data_view = mux_low;
            S3PM_IDX_MUX_HIGH: data_view = mux_high;
            default: data_view = 8'h00; // Other indices belong to other blocks
         endcase
      end
   end

   // Read multiplexer; unmapped offsets read as zero
   always_comb begin
      rd_value = 32'h0000_0000;
      case (address)
         S3PM_OFS_CTRL: rd_value = {31'h0000_0000, st_q.cfg};
         S3PM_OFS_INDEX: rd_value = {24'h00_0000, st_q.index};
         S3PM_OFS_DATA: rd_value = {24'h00_0000, data_view};
         S3PM_OFS_STATUS: rd_value = {16'h0000, mux_high, mux_low};
         default: rd_value = 32'h0000_0000;
      endcase
   end

   // Bus handshake and control state
   always_comb begin
      st_d = st_q;
      case (st_q.fsm)
         S3PM_FSM_IDLE: begin
            if (req) begin
               // Capture read data now; nothing else changes state before the answer
               st_d.fsm = S3PM_FSM_ACK;
               st_d.rdata = read ? rd_value : st_q.rdata;
            end
         end
         S3PM_FSM_ACK: begin
            st_d.fsm = S3PM_FSM_IDLE;
            if (write && lane0) begin
               if (address == S3PM_OFS_CTRL) begin
                  st_d.cfg = writedata[S3PM_CFG_BIT];
               end
               // The index only moves in configuration state
               if ((address == S3PM_OFS_INDEX) && st_q.cfg) begin
                  st_d.index = writedata[7:0];
               end
            end
         end
         default: begin
            st_d.fsm = S3PM_FSM_IDLE; // Recover from an illegal code
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_q.fsm <= S3PM_FSM_IDLE;
         st_q.cfg <= 1'b0;
         st_q.index <= S3PM_INDEX_RESET;
         st_q.rdata <= S3PM_RDATA_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign readdata = st_q.rdata;

   // The two mux registers
   s3pm_mux_reg u_mux_low (
      .clock(clock),
      .resetn(resetn),
      .wr_en(wr_low),
      .wr_data(writedata[7:0]),
      .value(mux_low)
   );

   s3pm_mux_reg u_mux_high (
      .clock(clock),
      .resetn(resetn),
      .wr_en(wr_high),
      .wr_data(writedata[7:0]),
      .value(mux_high)
   );

   // Serial outputs placed on their pads; input-only pads carry zero here
   assign alt_out = {port3_terminal_ready_n, 1'b0, port3_request_to_send_n, 1'b0,
                     port3_transmit_data, 3'h0};
   assign sel_all = {mux_high, mux_low};

   // One routing cell per pad, field i of the pair of registers steers pad i
   for (genvar i = 0; i < S3PM_PINS; i++) begin : g_pin
      s3pm_pin_cell #(
         .ALT_IS_OUTPUT(S3PM_ALT_OUT_MASK[i])
      ) u_cell (
         .sel(sel_all[S3PM_FIELD_W*i +: S3PM_FIELD_W]),
         .gpio_out(gpio_out[i]),
         .gpio_oe(gpio_oe[i]),
         .pad_in(pad_in[i]),
         .alt_out(alt_out[i]),
         .pad(pad_drv[i]),
         .gpio_in(gpio_in[i]),
         .alt_in(alt_in[i])
      );
      assign pad_out[i] = pad_drv[i].out;
      assign pad_oe[i] = pad_drv[i].oe;
   end

   // Serial inputs taken from their pads
   assign port3_ring_indicator_n = alt_in[0];
   assign port3_carrier_detect_n = alt_in[1];
   assign port3_receive_data = alt_in[2];
   assign port3_data_set_ready_n = alt_in[4];
   assign port3_clear_to_send_n = alt_in[6];

   // Steps of a data-window write
   sequence s_wr_low_taken;
      accept && write && lane0 && (address == S3PM_OFS_DATA) && st_q.cfg
         && (st_q.index == S3PM_IDX_MUX_LOW);
   endsequence

   sequence s_wr_high_taken;
      accept && write && lane0 && (address == S3PM_OFS_DATA) && st_q.cfg
         && (st_q.index == S3PM_IDX_MUX_HIGH);
   endsequence

   property p_low_write;
      @(posedge clock) disable iff (!resetn)
         s_wr_low_taken |=> (mux_low == $past(writedata[7:0]));
   endproperty
   a_low_write: assert property (p_low_write) else $error("low mux missed write");

   property p_high_write;
      @(posedge clock) disable iff (!resetn)
         s_wr_high_taken |=> (mux_high == $past(writedata[7:0])) && $stable(mux_low);
   endproperty
   a_high_write: assert property (p_high_write) else $error("high mux missed write");

   property p_no_cfg_no_write;
      @(posedge clock) disable iff (!resetn)
         (accept && write && !st_q.cfg) |=> $stable(mux_low) && $stable(mux_high);
   endproperty
   a_no_cfg_no_write: assert property (p_no_cfg_no_write) else $error("mux changed outside config");

   property p_readback;
      @(posedge clock) disable iff (!resetn)
         (accept && read && (address == S3PM_OFS_DATA) && st_q.cfg && (st_q.index == S3PM_IDX_MUX_HIGH))
            |-> (readdata == {24'h00_0000, mux_high});
   endproperty
   a_readback: assert property (p_readback) else $error("high mux readback wrong");

   property p_reset_zero;
      @(posedge clock) $rose(resetn) |-> (mux_low == 8'h00) && (mux_high == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("mux not zero after reset");

   property p_route_ring;
      @(posedge clock) disable iff (!resetn)
         (mux_low[1:0] == S3PM_FN_ALT) |-> (port3_ring_indicator_n == pad_in[0]);
   endproperty
   a_route_ring: assert property (p_route_ring) else $error("ring indicator not routed");

   property p_gpio_txd_pad;
      @(posedge clock) disable iff (!resetn)
         (mux_low[7:6] != S3PM_FN_ALT) |-> (pad_out[3] == gpio_out[3]);
   endproperty
   a_gpio_txd_pad: assert property (p_gpio_txd_pad) else $error("pad 33 not gpio");

   property p_route_rts;
      @(posedge clock) disable iff (!resetn)
         (mux_high[3:2] == S3PM_FN_ALT) |-> (pad_out[5] == port3_request_to_send_n);
   endproperty
   a_route_rts: assert property (p_route_rts) else $error("request to send not routed");

   property p_one_wait;
      @(posedge clock) disable iff (!resetn)
         (req && waitrequest) |=> (st_q.fsm == S3PM_FSM_ACK) ##1 (st_q.fsm == S3PM_FSM_IDLE);
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("handshake not one wait cycle");

   // Reads through the data window, for an open index and for refused ones
   sequence s_rd_low_taken;
      accept && read && (address == S3PM_OFS_DATA) && st_q.cfg && (st_q.index == S3PM_IDX_MUX_LOW);
   endsequence

   sequence s_rd_refused;
      accept && read && (address == S3PM_OFS_DATA)
         && (!st_q.cfg || ((st_q.index != S3PM_IDX_MUX_LOW) && (st_q.index != S3PM_IDX_MUX_HIGH)));
   endsequence

   // Writes that must leave the index or the mux registers alone
   sequence s_index_wr_locked;
      accept && write && lane0 && (address == S3PM_OFS_INDEX) && !st_q.cfg;
   endsequence

   sequence s_lane_off_write;
      accept && write && !lane0;
   endsequence

   // Read data were captured a cycle earlier, but nothing can move the mux in between
   property p_low_readback;
      @(posedge clock) disable iff (!resetn)
         s_rd_low_taken |-> (readdata == {24'h00_0000, mux_low});
   endproperty
   a_low_readback: assert property (p_low_readback) else $error("low mux readback wrong");

   property p_rd_refused;
      @(posedge clock) disable iff (!resetn)
         s_rd_refused |-> (readdata == 32'h0000_0000);
   endproperty
   a_rd_refused: assert property (p_rd_refused) else $error("data window read not refused");

   property p_index_locked;
      @(posedge clock) disable iff (!resetn)
         s_index_wr_locked |=> $stable(st_q.index);
   endproperty
   a_index_locked: assert property (p_index_locked) else $error("index moved outside config");

   property p_lane_off;
      @(posedge clock) disable iff (!resetn)
         s_lane_off_write |=> $stable(mux_low) && $stable(mux_high);
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("mux changed on lane-off write");

   property p_route_txd;
      @(posedge clock) disable iff (!resetn)
         (mux_low[7:6] == S3PM_FN_ALT) |-> (pad_out[3] == port3_transmit_data);
   endproperty
   a_route_txd: assert property (p_route_txd) else $error("transmit data not routed");

   property p_rxd_idle;
      @(posedge clock) disable iff (!resetn)
         (mux_low[5:4] != S3PM_FN_ALT) |-> (port3_receive_data == S3PM_ALT_IDLE);
   endproperty
   a_rxd_idle: assert property (p_rxd_idle) else $error("unrouted receive data not idle");

   property p_route_cts;
      @(posedge clock) disable iff (!resetn)
         (mux_high[5:4] == S3PM_FN_ALT) |-> (port3_clear_to_send_n == pad_in[6]);
   endproperty
   a_route_cts: assert property (p_route_cts) else $error("clear to send not routed");

   property p_route_term_ready;
      @(posedge clock) disable iff (!resetn)
         (mux_high[7:6] == S3PM_FN_ALT) |-> (pad_out[7] == port3_terminal_ready_n);
   endproperty
   a_route_term_ready: assert property (p_route_term_ready) else $error("terminal ready not routed");

   property p_gpio_pad37;
      @(posedge clock) disable iff (!resetn)
         (mux_high[7:6] != S3PM_FN_ALT) |-> (pad_out[7] == gpio_out[7]);
   endproperty
   a_gpio_pad37: assert property (p_gpio_pad37) else $error("pad 37 not gpio");
endmodule // s3pm_top

// ### tb/s3pm_tb_top.sv
// Self-checking bench for the serial-three pin function select block.
// Assumes the block answers each Avalon access in its own time; the watchdog bounds every wait.
module s3pm_tb_top
   import s3pm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock, resetn; // Clock and active-low reset
   logic [3:0] address, byteenable; // Bus request
   logic read, write, waitrequest;
   logic [31:0] writedata, readdata;
   logic [7:0] gpio_out, gpio_oe, gpio_in, pad_in, pad_out, pad_oe; // Pin side
   logic ri_n, dcd_n, rxd, txd, dsr_n, rts_n, cts_n, dtr_n; // Serial port side
   int error_cnt = 0; // Mismatches seen
   int comparisons = 0; // Compares made
   logic [15:0] mux_m; // Model: high mux in [15:8], low mux in [7:0]
   logic cfg_m; // Model: configuration state
   logic [7:0] idx_m; // Model: index register
   logic [31:0] rnd; // Scratch random word

   s3pm_top i_dut (.clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .port3_ring_indicator_n(ri_n), .port3_carrier_detect_n(dcd_n),
      .port3_receive_data(rxd), .port3_transmit_data(txd), .port3_data_set_ready_n(dsr_n),
      .port3_request_to_send_n(rts_n), .port3_clear_to_send_n(cts_n), .port3_terminal_ready_n(dtr_n));

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Reports a mismatch at once
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Single verdict point of the run
   task automatic end_of_test();
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // One Avalon access; holds the request until waitrequest is sampled low
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
      read <= rd;
      write <= ~rd;
      address <= a;
      writedata <= wd;
      @(posedge clock);
      // No cycle count assumed; only the watchdog ends a wait that never finishes
      while (waitrequest !== 1'b0) begin
         @(posedge clock);
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Idle edge so the next request never reassigns strobes in this step
      @(posedge clock);
   endtask

   // Write and mirror the effect in the model
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      logic [31:0] q;
      rnd = $urandom();
      bus(1'b0, a, {rnd[31:8], v}, q);
      if (!byteenable[0]) begin
         // Lane 0 off: the block drops the whole write
      end else if (a == S3PM_OFS_CTRL) cfg_m = v[S3PM_CFG_BIT];
      else if (a == S3PM_OFS_INDEX && cfg_m) idx_m = v;
      else if (a == S3PM_OFS_DATA && cfg_m && idx_m == S3PM_IDX_MUX_LOW) mux_m[7:0] = v;
      else if (a == S3PM_OFS_DATA && cfg_m && idx_m == S3PM_IDX_MUX_HIGH) mux_m[15:8] = v;
   endtask

   // Read and compare with the model
   task automatic reg_rd(input logic [3:0] a);
      logic [31:0] q, e;
      e = 32'h0000_0000;
      if (a == S3PM_OFS_CTRL) e = {31'h0000_0000, cfg_m};
      if (a == S3PM_OFS_INDEX) e = {24'h00_0000, idx_m};
      if (a == S3PM_OFS_STATUS) e = {16'h0000, mux_m};
      if (a == S3PM_OFS_DATA && cfg_m && idx_m == S3PM_IDX_MUX_LOW) e = {24'h0, mux_m[7:0]};
      if (a == S3PM_OFS_DATA && cfg_m && idx_m == S3PM_IDX_MUX_HIGH) e = {24'h0, mux_m[15:8]};
      bus(1'b1, a, 32'h0000_0000, q);
      check(q, e);
   endtask

   // Random pin stimulus, then pin routing against the model
   task automatic pins();
      logic [7:0] po, ai, sel1, src, oe_v;
      rnd = $urandom();
      for (int i = 0; i < 8; i++) begin
         // Only code 01 routes; reserved codes act as plain GPIO
         sel1[i] = (mux_m[2*i +: 2] == 2'h1);
      end
      // Software sets the direction of each pad to suit its selected serial function
      oe_v = (rnd[31:24] & ~sel1) | (sel1 & S3PM_ALT_OUT_MASK);
      gpio_out <= rnd[7:0];
      gpio_oe <= oe_v;
      pad_in <= rnd[15:8];
      txd <= rnd[16];
      rts_n <= rnd[17];
      dtr_n <= rnd[18];
      src = {rnd[18], 1'b0, rnd[17], 1'b0, rnd[16], 3'h0};
      @(negedge clock);
      for (int i = 0; i < 8; i++) begin
         po[i] = (sel1[i] && S3PM_ALT_OUT_MASK[i]) ? src[i] : gpio_out[i];
         ai[i] = sel1[i] ? pad_in[i] : 1'b1;
      end
      check(pad_out, po);
      check({cts_n, dsr_n, rxd, dcd_n, ri_n}, {ai[6], ai[4], ai[2], ai[1], ai[0]});
      check(pad_oe, oe_v);
      check(gpio_in, pad_in);
      @(posedge clock);
   endtask

   // Standby power-on reset, usable at start and in mid-run
   task automatic do_reset();
      resetn <= 1'b0;
      mux_m = 16'h0000;
      cfg_m = 1'b0;
      idx_m = S3PM_INDEX_RESET;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
   endtask

   // Watchdog sized well above the expected run of about a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      end_of_test();
   end

   // Main sequence
   initial begin
      void'($urandom(32'h9029));
      {read, write, address, writedata} = '0;
      {gpio_out, gpio_oe, pad_in, txd, rts_n, dtr_n} = '0;
      byteenable = 4'hf;
      // Reset is asserted from time zero and held over two rising edges
      do_reset();
      reg_rd(S3PM_OFS_STATUS);
      pins();
      // Index and data-window accesses outside configuration state must be ignored
      reg_wr(S3PM_OFS_INDEX, S3PM_IDX_MUX_LOW);
      reg_wr(S3PM_OFS_DATA, 8'h55);
      reg_rd(S3PM_OFS_DATA);
      reg_rd(S3PM_OFS_STATUS);
      reg_wr(4'h2, 8'hff);
      reg_rd(4'h2);
      for (int k = 0; k < 40; k++) begin
         // Leave configuration state for a stretch in mid-run
         reg_wr(S3PM_OFS_CTRL, {7'h00, (k < 20 || k > 24)});
         if (k % 5 == 4) reg_wr(S3PM_OFS_INDEX, 8'h4a);
         else reg_wr(S3PM_OFS_INDEX, k[0] ? S3PM_IDX_MUX_HIGH : S3PM_IDX_MUX_LOW);
         rnd = $urandom();
         // Now and then a write with lane 0 off, which the block must ignore
         byteenable <= (k % 7 == 3) ? 4'he : 4'hf;
         reg_wr(S3PM_OFS_DATA, rnd[7:0]);
         byteenable <= 4'hf;
         reg_rd(S3PM_OFS_CTRL);
         reg_rd(S3PM_OFS_INDEX);
         reg_rd(S3PM_OFS_DATA);
         reg_rd(S3PM_OFS_STATUS);
         pins();
      end
      do_reset();
      reg_rd(S3PM_OFS_STATUS);
      pins();
      end_of_test();
   end
endmodule // s3pm_tb_top
